/* rtl/dlp_host.sv */
`timescale 1ns/10ps
module dlp_host import dlp_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire dlp_video_s video_i,
  output logic pix_take_o,
  output dlp_link_s [NUM_LINKS-1:0] link_o,
  output logic [NUM_LINKS-1:0] dot_clock_o,
  input wire logic dig_ctrl_en_i,
  input wire logic cmd_start_i,
  input wire logic cmd_port_i,
  input wire logic [7:0] cmd_value_i,
  output logic cmd_busy_o,
  output logic cmd_done_o,
  output logic cmd_nack_o,
  output logic cmd_refused_o,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  // ****************************************
  // video links
  // ****************************************
  logic dot_div_r;
  dlp_link_s [NUM_LINKS-1:0] link_nxt;

  // divide by two: the 65 MHz figure is typical only, 50 MHz is what clk_i gives
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dot_div_r <= 1'b0;
    end else begin
      dot_div_r <= ~dot_div_r; // [RULE7]
    end
  end

  // one clock per link, all from the same divider [RULE6]
  genvar gl;
  generate
    for (gl = 0; gl < NUM_LINKS; gl++) begin : g_link
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          dot_clock_o[gl] <= 1'b0;
        end else begin
          dot_clock_o[gl] <= ~dot_div_r; // [RULE6]
        end
      end

      // pixel bits on pairs zero and one; timing only on even links [RULE4] [RULE5]
      always_comb begin
        link_nxt[gl] = '0;
        link_nxt[gl].pair0 = video_i.pix[gl][PAIR_BITS-1:0];
        link_nxt[gl].pair1[0] = video_i.pix[gl][PIX_BITS-1];
        if ((gl == LINK_LE) || (gl == LINK_RE)) begin
          link_nxt[gl].pair2[SYNC_H_POS] = video_i.hsync; // [RULE8]
          link_nxt[gl].pair2[SYNC_V_POS] = video_i.vsync; // [RULE8]
          link_nxt[gl].pair2[SYNC_DE_POS] = video_i.display_enable_window; // [RULE8]
        end
      end
    end
  endgenerate

  // data changes with the rising dot clock so it stands still at the falling edge
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_o <= '0;
      pix_take_o <= 1'b0;
    end else begin
      // no frame store here: each set goes out on the next dot clock
      pix_take_o <= ~dot_div_r; // [RULE1]
      if (!dot_div_r) begin
        link_o <= link_nxt; // [RULE14] [RULE15] [RULE2] [RULE3]
      end
    end
  end

  // ****************************************
  // control serial port master
  // ****************************************
  logic sda_meta_r;
  logic sda_sync_r;
  dlp_i2c_e state_r;
  logic [8:0] qcnt_r;
  logic [1:0] ph_r;
  logic [1:0] byte_r;
  logic [2:0] bit_r;
  logic [7:0] shift_r;
  logic [NUM_BYTES-1:0][7:0] bytes_r;
  logic tick;
  logic addr_ok;
  logic [7:0] value_nxt;

  localparam logic [8:0] QTR_LAST = 9'(QTR_CYC - 1);

  assign tick = (qcnt_r == QTR_LAST);
  // never send to a reserved range [RULE12] [RULE13]
  assign addr_ok = !((PANEL_ADDR >= RSV_A_LO) && (PANEL_ADDR <= RSV_A_HI)) &&
                   !((PANEL_ADDR >= RSV_B_LO) && (PANEL_ADDR <= RSV_B_HI));
  // contrast above the bright end is clamped
  assign value_nxt = ((cmd_port_i == PORT_CONTRAST) && (cmd_value_i > CONTRAST_BRIGHT)) ?
                     CONTRAST_BRIGHT : cmd_value_i; // [RULE16]

  // data line comes from the pin, two flops before use
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end else begin
      sda_meta_r <= sda_i;
      sda_sync_r <= sda_meta_r;
    end
  end

  // quarter bit timer and phase, idle outside a transfer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      qcnt_r <= '0;
      ph_r <= '0;
    end else if (state_r == I2C_IDLE) begin
      qcnt_r <= '0;
      ph_r <= '0;
    end else if (tick) begin
      qcnt_r <= '0;
      ph_r <= ph_r + 2'h1;
    end else begin
      qcnt_r <= qcnt_r + 9'h1;
    end
  end

  // byte sequencer and line drive; enables high pull the lines low
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= I2C_IDLE;
      byte_r <= '0;
      bit_r <= '0;
      shift_r <= '0;
      bytes_r <= '0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      cmd_busy_o <= 1'b0;
      cmd_done_o <= 1'b0;
      cmd_nack_o <= 1'b0;
      cmd_refused_o <= 1'b0;
    end else begin
      cmd_done_o <= 1'b0;
      cmd_refused_o <= 1'b0;
      case (state_r)
        I2C_IDLE: begin
          if (cmd_start_i) begin
            // analogue mode leaves the serial port unused [RULE9]
            if (dig_ctrl_en_i && addr_ok) begin
              bytes_r[0] <= {PANEL_ADDR, 1'b0}; // [RULE10]
              bytes_r[1] <= POT_CMD_BASE | {7'h00, cmd_port_i}; // [RULE11]
              bytes_r[2] <= value_nxt;
              cmd_nack_o <= 1'b0;
              cmd_busy_o <= 1'b1;
              state_r <= I2C_START;
            end else begin
              cmd_refused_o <= 1'b1;
            end
          end
        end
        I2C_START: begin
          if (tick) begin
            case (ph_r)
              2'h1: sda_oe_o <= 1'b1;
              2'h3: begin
                scl_oe_o <= 1'b1;
                byte_r <= '0;
                bit_r <= 3'h7;
                shift_r <= bytes_r[0];
                state_r <= I2C_BIT;
              end
              default: ;
            endcase
          end
        end
        I2C_BIT: begin
          if (tick) begin
            case (ph_r)
              2'h0: sda_oe_o <= ~shift_r[7];
              2'h1: scl_oe_o <= 1'b0;
              2'h3: begin
                scl_oe_o <= 1'b1;
                if (bit_r == 3'h0) begin
                  state_r <= I2C_ACK;
                end else begin
                  bit_r <= bit_r - 3'h1;
                  shift_r <= {shift_r[6:0], 1'b0};
                end
              end
              default: ;
            endcase
          end
        end
        I2C_ACK: begin
          if (tick) begin
            case (ph_r)
              2'h0: sda_oe_o <= 1'b0;
              2'h1: scl_oe_o <= 1'b0;
              2'h2: cmd_nack_o <= sda_sync_r; // [RULE17]
              2'h3: begin
                scl_oe_o <= 1'b1;
                if (cmd_nack_o || (byte_r == 2'(NUM_BYTES - 1))) begin
                  state_r <= I2C_STOP;
                end else begin
                  byte_r <= byte_r + 2'h1;
                  bit_r <= 3'h7;
                  shift_r <= bytes_r[byte_r + 2'h1];
                  state_r <= I2C_BIT;
                end
              end
              default: ;
            endcase
          end
        end
        I2C_STOP: begin
          if (tick) begin
            case (ph_r)
              2'h0: sda_oe_o <= 1'b1;
              2'h1: scl_oe_o <= 1'b0;
              2'h2: sda_oe_o <= 1'b0;
              2'h3: begin
                cmd_busy_o <= 1'b0;
                cmd_done_o <= 1'b1;
                state_r <= I2C_IDLE;
              end
              default: ;
            endcase
          end
        end
        default: begin
          state_r <= I2C_IDLE;
          scl_oe_o <= 1'b0;
          sda_oe_o <= 1'b0;
          cmd_busy_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* rtl/dlp_pkg.sv */
// Function
// RULE1: source scales and keeps frame-locked timing
// RULE2: four links, two channels, one per half
// RULE3: even dots and odd dots on separate links
// RULE4: even link: four pairs, pixels plus timing
// RULE5: odd link: four pairs, pixels only
// RULE6: own dot clock for every link
// RULE7: typical 65 MHz dot clock per link
// RULE8: syncs and enable on even pair two
// RULE9: brightness/contrast by voltage or serial port
// RULE10: control target address is 0101101
// RULE11: port zero contrast, port one brightness
// RULE12: addresses 0010000-0011111 stay reserved
// RULE13: addresses 0110000-0111111 stay reserved
// RULE14: data valid on dot clock falling edge
// RULE15: syncs and enable follow dot clock
// RULE16: contrast 00 dark, 50 nominal, d0 bright
// RULE17: target answers only its own address
// RULE18: panel deserialises each link on own clock
package dlp_pkg;

  // ****************************************
  // link layout
  // ****************************************
  localparam int NUM_LINKS = 4;
  localparam int PAIR_BITS = 7;
  localparam int PIX_BITS = 8;
  // link index: left even, left odd, right even, right odd
  localparam int LINK_LE = 0;
  localparam int LINK_LO = 1;
  localparam int LINK_RE = 2;
  localparam int LINK_RO = 3;
  // timing bit positions inside pair two of an even link
  localparam int SYNC_H_POS = 4;
  localparam int SYNC_V_POS = 5;
  localparam int SYNC_DE_POS = 6;

  typedef struct packed {
    logic [PAIR_BITS-1:0] pair3;
    logic [PAIR_BITS-1:0] pair2;
    logic [PAIR_BITS-1:0] pair1;
    logic [PAIR_BITS-1:0] pair0;
  } dlp_link_s;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic display_enable_window;
    logic [NUM_LINKS-1:0][PIX_BITS-1:0] pix;
  } dlp_video_s;

  // ****************************************
  // control serial port
  // ****************************************
  localparam logic [6:0] PANEL_ADDR = 7'h2d;
  localparam logic [6:0] RSV_A_LO = 7'h10;
  localparam logic [6:0] RSV_A_HI = 7'h1f;
  localparam logic [6:0] RSV_B_LO = 7'h30;
  localparam logic [6:0] RSV_B_HI = 7'h3f;
  localparam logic PORT_CONTRAST = 1'b0;
  localparam logic PORT_BRIGHTNESS = 1'b1;
  localparam logic [7:0] CONTRAST_DARK = 8'h00;
  localparam logic [7:0] CONTRAST_NOMINAL = 8'h50;
  localparam logic [7:0] CONTRAST_BRIGHT = 8'hd0;
  // potentiometer command base; port index is or-ed into bit 0 (arbitrary value)
  localparam logic [7:0] POT_CMD_BASE = 8'h00;
  localparam int NUM_BYTES = 3;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int I2C_QUARTER_NS = 2500;
  localparam int QTR_CYC = (I2C_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_START = 3'h1,
    I2C_BIT = 3'h3,
    I2C_ACK = 3'h2,
    I2C_STOP = 3'h6
  } dlp_i2c_e;

endpackage

/* verification/dlp_host_sva.sv */
`timescale 1ns/10ps
module dlp_host_chk import dlp_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire dlp_video_s video_i,
  input wire logic pix_take_o,
  input wire dlp_link_s [NUM_LINKS-1:0] link_o,
  input wire logic [NUM_LINKS-1:0] dot_clock_o,
  input wire logic dig_ctrl_en_i,
  input wire logic cmd_start_i,
  input wire logic cmd_busy_o,
  input wire logic cmd_done_o,
  input wire logic cmd_refused_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // link words are checked against the set sampled one edge before
  property p_dclk; dot_clock_o[0] |=> !dot_clock_o[0] ##1 dot_clock_o[0]; endproperty
  property p_same; dot_clock_o == {NUM_LINKS{dot_clock_o[0]}}; endproperty
  property p_take; pix_take_o |-> $rose(dot_clock_o[0]); endproperty
  property p_hold; dot_clock_o[0] |=> $stable(link_o); endproperty
  property p_even; pix_take_o |-> link_o[LINK_RE].pair2[6:4] ==
    {$past(video_i.display_enable_window), $past(video_i.vsync), $past(video_i.hsync)}; endproperty
  property p_odd; pix_take_o |-> link_o[LINK_LO].pair2 == 7'h00 &&
    {link_o[LINK_LO].pair1[0], link_o[LINK_LO].pair0} == $past(video_i.pix[LINK_LO]); endproperty
  property p_acc; cmd_start_i && dig_ctrl_en_i && !cmd_busy_o && !cmd_done_o |=> cmd_busy_o;
  endproperty
  property p_ref; cmd_start_i && !dig_ctrl_en_i && !cmd_busy_o |=> cmd_refused_o && !cmd_busy_o;
  endproperty
  // a start during a transfer neither refuses nor breaks the running one
  property p_drop; cmd_start_i && cmd_busy_o |=> !cmd_refused_o && (cmd_busy_o || cmd_done_o);
  endproperty
  a_dclk: assert property (p_dclk) else $error("dot clock not square");
  a_same: assert property (p_same) else $error("dot clocks differ");
  a_take: assert property (p_take) else $error("take off dot clock");
  a_hold: assert property (p_hold) else $error("link moved at fall");
  a_even: assert property (p_even) else $error("timing bits wrong");
  a_odd: assert property (p_odd) else $error("odd link wrong");
  a_acc: assert property (p_acc) else $error("start not taken");
  a_ref: assert property (p_ref) else $error("start not refused");
  a_drop: assert property (p_drop) else $error("start taken while busy");
  c_take: cover property (pix_take_o);
  c_done: cover property (cmd_done_o);
  c_ref: cover property (cmd_refused_o);
endmodule
bind dlp_host dlp_host_chk u_chk (.clk_i, .sys_rst_i, .video_i, .pix_take_o, .link_o,
  .dot_clock_o, .dig_ctrl_en_i, .cmd_start_i, .cmd_busy_o, .cmd_done_o, .cmd_refused_o);

/* verification/dlp_panel_model.sv */
`timescale 1ns/10ps
// serial control target of the panel, behavioural
module dlp_panel_model import dlp_pkg::*; (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic deaf_i,
  output logic sda_oe_o,
  output logic [7:0] contrast_o,
  output logic [7:0] bright_o
);
  int bitn = 10;
  int byten = 0;
  logic [7:0] sh = 8'h00;
  logic me = 1'b0;
  logic port = 1'b0;
  initial begin
    sda_oe_o = 1'b0;
    contrast_o = 8'h55; // arbitrary power-up setting
    bright_o = 8'h55;
  end
  // start: data falls while the clock line is high
  always @(negedge sda_i) begin
    if (scl_i) begin
      bitn = 0;
      byten = 0;
    end
  end
  // bits taken on the rising clock, msb first
  always @(posedge scl_i) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda_i};
      bitn++;
    end
  end
  // ack only our own address; reserved ranges stay silent
  always @(negedge scl_i) begin
    if (bitn == 8) begin
      if (byten == 0) me = (sh == {PANEL_ADDR, 1'b0}) && !deaf_i;
      if (byten == 1) port = sh[0];
      if (byten == 2 && me && port == PORT_CONTRAST) contrast_o = sh;
      if (byten == 2 && me && port == PORT_BRIGHTNESS) bright_o = sh;
      sda_oe_o = me;
      bitn = 9;
    end else if (bitn == 9) begin
      sda_oe_o = 1'b0;
      bitn = 0;
      byten++;
    end
  end
endmodule

/* verification/dual_channel_lvds_pixel_input_test.sv */
`timescale 1ns/10ps
module dual_channel_lvds_pixel_input_test import dlp_pkg::*; ;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  dlp_video_s video_i = '0;
  logic dig_ctrl_en_i = 1'b0;
  logic cmd_start_i = 1'b0;
  logic cmd_port_i = 1'b0;
  logic [7:0] cmd_value_i = 8'h00;
  logic deaf = 1'b0;
  logic pix_take_o, cmd_busy_o, cmd_done_o, cmd_nack_o, cmd_refused_o;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, tgt_oe, scl, sda, dclk_prev;
  dlp_link_s [NUM_LINKS-1:0] link_o;
  logic [NUM_LINKS-1:0] dot_clock_o;
  logic [7:0] contrast, bright, b;
  logic [63:0] rnd;
  logic [111:0] q_v[$];
  logic [111:0] q_c[$];
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int refusals = 0;
  // open-drain lines with pull-ups
  assign scl = scl_oe_o ? scl_o : 1'b1;
  assign sda = (sda_oe_o ? sda_o : 1'b1) & ~tgt_oe;
  dlp_host u_dut (.clk_i, .sys_rst_i, .video_i, .pix_take_o, .link_o, .dot_clock_o,
    .dig_ctrl_en_i, .cmd_start_i, .cmd_port_i, .cmd_value_i, .cmd_busy_o, .cmd_done_o,
    .cmd_nack_o, .cmd_refused_o, .scl_o, .scl_oe_o, .sda_i(sda), .sda_o, .sda_oe_o);
  dlp_panel_model u_panel (.scl_i(scl), .sda_i(sda), .deaf_i(deaf), .sda_oe_o(tgt_oe),
    .contrast_o(contrast), .bright_o(bright));
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [111:0] exp_link(input dlp_video_s v);
    dlp_link_s [NUM_LINKS-1:0] l;
    l = '0;
    for (int k = 0; k < NUM_LINKS; k++) begin
      {l[k].pair1[0], l[k].pair0} = v.pix[k];
      if (k % 2 == 0) l[k].pair2[6:4] = {v.display_enable_window, v.vsync, v.hsync};
    end
    return l;
  endfunction
  task automatic check(input logic [111:0] seen, input logic [111:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmd(input logic p, input logic [7:0] v, input logic [16:0] e, input bit push);
    cmd_port_i = p;
    cmd_value_i = v;
    cmd_start_i = 1'b1;
    if (push) q_c.push_back({95'h0, e});
    @(posedge clk_i);
    #1 cmd_start_i = 1'b0;
    repeat (40000) begin
      @(posedge clk_i);
      if (!push || cmd_done_o === 1'b1) break;
    end
    #1;
  endtask
  // hang limit: running out counts as a mismatch and ends the run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      mismatches++;
      close_out();
    end
  end
  // fresh pixels each time a set is taken
  always @(posedge clk_i) begin
    #1;
    if (pix_take_o === 1'b1) begin
      rnd = {$urandom, $urandom};
      video_i = rnd[34:0];
      q_v.push_back(exp_link(video_i));
    end
  end
  // panel side: links read on the falling dot clock, results on done
  always @(negedge clk_i) begin
    if (!sys_rst_i && dclk_prev && !dot_clock_o[0]) check(link_o, q_v.pop_front());
    if (cmd_done_o === 1'b1) check({95'h0, cmd_nack_o, contrast, bright}, q_c.pop_front());
    if (cmd_refused_o === 1'b1) refusals++;
    dclk_prev = dot_clock_o[0];
  end
  initial begin
    void'($urandom(52));
    q_v.push_back(exp_link(video_i));
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    cmd(PORT_CONTRAST, 8'h50, 17'h0, 1'b0);
    check(112'(refusals), 112'd1);
    dig_ctrl_en_i = 1'b1;
    // a second request while busy must be dropped
    fork
      begin
        repeat (300) @(posedge clk_i);
        #1 cmd_start_i = 1'b1;
        @(posedge clk_i);
        #1 cmd_start_i = 1'b0;
      end
    join_none
    cmd(PORT_CONTRAST, 8'hff, {1'b0, CONTRAST_BRIGHT, 8'h55}, 1'b1);
    b = 8'($urandom);
    cmd(PORT_BRIGHTNESS, b, {1'b0, CONTRAST_BRIGHT, b}, 1'b1);
    deaf = 1'b1;
    cmd(PORT_BRIGHTNESS, ~b, {1'b1, CONTRAST_BRIGHT, b}, 1'b1);
    repeat (4) @(posedge clk_i);
    close_out();
  end
endmodule
